// ===== core/ict_consts.svh
// Constants of the instruction cycle timing core: data addresses, fields, timing.
// Assumes inclusion by ict_pkg.sv, ict_core.sv and the self-checking bench.
//
// Summary of operation
// - Instruction cycle is four system clocks
// - Branches, calls, returns, table reads take two
// - Writing program counter low byte jumps, plus one
// - Skip adds one cycle only when taken
// - Add carries above 255, subtract borrows below zero
// - Increment and decrement change operand by one
// - Logical results set zero flag when zero
// - Rotate one bit; carry variants rotate through carry
// - Call saves next address; return resumes there
// - Skip tests memory byte or bit condition
// - Bit force changes only the selected bit
// - Table reads fetch program memory into registers
// - Data operations go through the accumulator
// - Power-down instruction; watchdog clear instruction
`ifndef ICT_CONSTS_SVH
`define ICT_CONSTS_SVH

// Timing
`define ICT_CLKS_PER_CYCLE 4
`define ICT_LAST_PHASE 2'h3
`define ICT_PRE_LAST_PHASE 2'h2

// Widths
`define ICT_PC_W 12
`define ICT_IW 18
`define ICT_STACK_DEPTH 8

// Instruction word fields
`define ICT_F_OP_HI 17
`define ICT_F_OP_LO 12
`define ICT_F_DEST 11
`define ICT_F_BIT_HI 10
`define ICT_F_BIT_LO 8
`define ICT_F_ARG_HI 7
`define ICT_F_ARG_LO 0
`define ICT_F_TGT_HI 11

// Special data memory addresses
`define ICT_ADDR_PC_LOW 8'h02
`define ICT_ADDR_TBL_PTR 8'h07
`define ICT_ADDR_TBL_HIGH 8'h08
`define ICT_ADDR_PORT_OUT 8'h14
`define ICT_ADDR_PORT_IN 8'h15

// Reset values
`define ICT_RST_PC 12'h000
`define ICT_RST_BYTE 8'h00

`endif

// ===== core/ict_pkg.sv
// Types of the instruction cycle timing core: operation codes.
// Assumes ict_consts.svh is on the include path.
`include "ict_consts.svh"

package ict_pkg;

	typedef enum logic [5:0] {
		ICT_OP_NOP = 6'h00,
		ICT_OP_MOVE_A_M = 6'h01,
		ICT_OP_MOVE_M_A = 6'h02,
		ICT_OP_MOVE_A_X = 6'h03,
		ICT_OP_ADD = 6'h04,
		ICT_OP_ADD_CARRY = 6'h05,
		ICT_OP_SUB = 6'h06,
		ICT_OP_SUB_CARRY = 6'h07,
		ICT_OP_ADD_X = 6'h08,
		ICT_OP_SUB_X = 6'h09,
		ICT_OP_SUB_CARRY_X = 6'h0A,
		ICT_OP_AND = 6'h0B,
		ICT_OP_OR = 6'h0C,
		ICT_OP_XOR = 6'h0D,
		ICT_OP_AND_X = 6'h0E,
		ICT_OP_OR_X = 6'h0F,
		ICT_OP_XOR_X = 6'h10,
		ICT_OP_BITWISE_COMPLEMENT = 6'h11,
		ICT_OP_INCREMENT = 6'h12,
		ICT_OP_SUBTRACT_ONE_FROM_MEMORY = 6'h13,
		ICT_OP_ROTATE_RIGHT = 6'h14,
		ICT_OP_ROTATE_LEFT = 6'h15,
		ICT_OP_ROTATE_RIGHT_VIA_FLAG = 6'h16,
		ICT_OP_ROTATE_LEFT_VIA_FLAG = 6'h17,
		ICT_OP_BIT_FORCE_HIGH = 6'h18,
		ICT_OP_BIT_FORCE_LOW = 6'h19,
		ICT_OP_SKIP_ZERO = 6'h1A,
		ICT_OP_SKIP_NOT_ZERO = 6'h1B,
		ICT_OP_SKIP_BIT_ZERO = 6'h1C,
		ICT_OP_SKIP_BIT_SET = 6'h1D,
		ICT_OP_UNCONDITIONAL_BRANCH = 6'h1E,
		ICT_OP_CALL = 6'h1F,
		ICT_OP_SUBROUTINE_RETURN = 6'h20,
		ICT_OP_INTERRUPT_RETURN = 6'h21,
		ICT_OP_TABLE_READ = 6'h22,
		ICT_OP_HALT = 6'h23,
		ICT_OP_WATCHDOG_CLEAR = 6'h24
	} ict_op_e;

	typedef logic [`ICT_PC_W-1:0] ict_addr_t;

endpackage

// ===== core/ict_alu.sv
// Eight-bit arithmetic, logic, rotate and bit unit of the core.
// Purely combinational; the core supplies operands and decides where results go.
module ict_alu (
	// Operation and operands
	input ict_pkg::ict_op_e op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic c_in,
	input wire logic [2:0] bit_sel,
	// Result and flags
	output logic [7:0] res,
	output logic c_out,
	output logic c_we,
	output logic z_we
);
	import ict_pkg::*;

	logic [8:0] sum9;
	logic [7:0] mask;

	always_comb begin
		sum9 = 9'h000;
		mask = 8'h01 << bit_sel;
		res = b;
		c_out = c_in;
		c_we = 1'b0;
		z_we = 1'b0;
		unique case (op)
			ICT_OP_ADD, ICT_OP_ADD_X, ICT_OP_ADD_CARRY: begin
				sum9 = {1'b0, a} + {1'b0, b} + {8'h00, (op == ICT_OP_ADD_CARRY) & c_in};
				res = sum9[7:0];
				c_out = sum9[8];
				c_we = 1'b1;
				z_we = 1'b1;
			end
			ICT_OP_SUB, ICT_OP_SUB_X: begin
				// Carry out of a + ~b + 1 is high exactly when no borrow occurs
				sum9 = {1'b0, a} + {1'b0, ~b} + 9'h001;
				res = sum9[7:0];
				c_out = sum9[8];
				c_we = 1'b1;
				z_we = 1'b1;
			end
			ICT_OP_SUB_CARRY, ICT_OP_SUB_CARRY_X: begin
				sum9 = {1'b0, a} + {1'b0, ~b} + {8'h00, c_in};
				res = sum9[7:0];
				c_out = sum9[8];
				c_we = 1'b1;
				z_we = 1'b1;
			end
			ICT_OP_AND, ICT_OP_AND_X: begin
				res = a & b;
				z_we = 1'b1;
			end
			ICT_OP_OR, ICT_OP_OR_X: begin
				res = a | b;
				z_we = 1'b1;
			end
			ICT_OP_XOR, ICT_OP_XOR_X: begin
				res = a ^ b;
				z_we = 1'b1;
			end
			ICT_OP_BITWISE_COMPLEMENT: begin
				res = ~b;
				z_we = 1'b1;
			end
			ICT_OP_INCREMENT: begin
				res = b + 8'h01;
				z_we = 1'b1;
			end
			ICT_OP_SUBTRACT_ONE_FROM_MEMORY: begin
				res = b - 8'h01;
				z_we = 1'b1;
			end
			ICT_OP_ROTATE_RIGHT: res = {b[0], b[7:1]};
			ICT_OP_ROTATE_LEFT: res = {b[6:0], b[7]};
			ICT_OP_ROTATE_RIGHT_VIA_FLAG: begin
				res = {c_in, b[7:1]};
				c_out = b[0];
				c_we = 1'b1;
			end
			ICT_OP_ROTATE_LEFT_VIA_FLAG: begin
				res = {b[6:0], c_in};
				c_out = b[7];
				c_we = 1'b1;
			end
			ICT_OP_BIT_FORCE_HIGH: res = b | mask;
			ICT_OP_BIT_FORCE_LOW: res = b & ~mask;
			default: res = b;
		endcase
	end

endmodule

// ===== core/ict_core.sv
// Instruction sequencer of the eight-bit core: four-clock cycles, fetch,
// execute, skips, branches, call stack, table reads, power-down.
// Assumes program memory returns the word at pmem_addr by the last clock of
// each cycle; port_in and wake_pin are asynchronous pins.
`include "ict_consts.svh"

module ict_core (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Program memory
	output ict_pkg::ict_addr_t pmem_addr,
	input wire logic [`ICT_IW-1:0] pmem_data,
	// Port pins
	input wire logic [7:0] port_in,
	output logic [7:0] port_out,
	// Wake-up pin
	input wire logic wake_pin,
	// Status
	output logic [7:0] acc,
	output logic carry_flag,
	output logic zero_flag,
	output logic cycle_strobe,
	output logic powered_down,
	output logic wdt_clear
);
	import ict_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	logic [1:0] phase_reg, phase_next;
	ict_addr_t pc_reg, pc_next;
	ict_addr_t pmem_addr_reg, pmem_addr_next;
	logic [7:0] acc_reg, acc_next;
	logic c_reg, c_next;
	logic z_reg, z_next;
	logic [2:0] sp_reg, sp_next;
	logic flush_reg, flush_next;
	logic tbl_pend_reg, tbl_pend_next;
	logic [7:0] tbl_dst_reg, tbl_dst_next;
	logic [7:0] tbl_high_reg, tbl_high_next;
	logic [7:0] port_out_reg, port_out_next;
	logic halted_reg, halted_next;
	logic wdt_clear_reg, wdt_clear_next;
	logic strobe_reg, strobe_next;
	logic [7:0] port_meta_reg, port_sync_reg;
	logic wake_meta_reg, wake_sync_reg;

	logic [7:0] dmem [0:255];
	ict_addr_t stack [0:`ICT_STACK_DEPTH-1];

	logic mem_we;
	logic [7:0] mem_wa, mem_wd;
	logic stk_we;

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	ict_op_e op;
	logic dest_m;
	logic [2:0] bit_sel;
	logic [7:0] arg;
	ict_addr_t target, pc_inc, tbl_addr;
	logic [7:0] rd_val, b_opnd, alu_res;
	logic alu_c, alu_cwe, alu_zwe;
	logic exec, is_imm, is_dual, is_skip, skip_take, to_pc_low;
	logic [2:0] stk_idx;
	ict_addr_t stk_top;

	assign op = ict_op_e'(pmem_data[`ICT_F_OP_HI:`ICT_F_OP_LO]);
	assign dest_m = pmem_data[`ICT_F_DEST];
	assign bit_sel = pmem_data[`ICT_F_BIT_HI:`ICT_F_BIT_LO];
	assign arg = pmem_data[`ICT_F_ARG_HI:`ICT_F_ARG_LO];
	assign target = pmem_data[`ICT_F_TGT_HI:`ICT_F_ARG_LO];
	assign pc_inc = pc_reg + 12'h001;
	assign stk_idx = sp_reg - 3'h1;
	assign stk_top = stack[stk_idx];
	assign tbl_addr = {pc_reg[11:8], dmem[`ICT_ADDR_TBL_PTR]};

	// Only the last clock of a cycle executes; the others wait for the fetch
	assign exec = (phase_reg == `ICT_LAST_PHASE) && !halted_reg && !flush_reg
		&& !tbl_pend_reg;

	assign is_imm = op inside {ICT_OP_MOVE_A_X, ICT_OP_ADD_X, ICT_OP_SUB_X,
		ICT_OP_SUB_CARRY_X, ICT_OP_AND_X, ICT_OP_OR_X, ICT_OP_XOR_X};
	assign is_dual = op inside {ICT_OP_ADD, ICT_OP_ADD_CARRY, ICT_OP_SUB,
		ICT_OP_SUB_CARRY, ICT_OP_AND, ICT_OP_OR, ICT_OP_XOR, ICT_OP_BITWISE_COMPLEMENT,
		ICT_OP_INCREMENT, ICT_OP_SUBTRACT_ONE_FROM_MEMORY, ICT_OP_ROTATE_RIGHT,
		ICT_OP_ROTATE_LEFT, ICT_OP_ROTATE_RIGHT_VIA_FLAG, ICT_OP_ROTATE_LEFT_VIA_FLAG};
	assign is_skip = op inside {ICT_OP_SKIP_ZERO, ICT_OP_SKIP_NOT_ZERO,
		ICT_OP_SKIP_BIT_ZERO, ICT_OP_SKIP_BIT_SET};

	// Special addresses other than the table pointer shadow the array; the port latch is read, not the pins,
	// so bit forcing on the port never copies pin levels into other bits
	always_comb begin
		unique case (arg)
			`ICT_ADDR_PC_LOW: rd_val = pc_reg[7:0];
			`ICT_ADDR_TBL_HIGH: rd_val = tbl_high_reg;
			`ICT_ADDR_PORT_OUT: rd_val = port_out_reg;
			`ICT_ADDR_PORT_IN: rd_val = port_sync_reg;
			default: rd_val = dmem[arg];
		endcase
	end

	assign b_opnd = is_imm ? arg : ((op == ICT_OP_MOVE_M_A) ? acc_reg : rd_val);

	always_comb begin
		unique case (op)
			ICT_OP_SKIP_ZERO: skip_take = (rd_val == 8'h00);
			ICT_OP_SKIP_NOT_ZERO: skip_take = (rd_val != 8'h00);
			ICT_OP_SKIP_BIT_ZERO: skip_take = !rd_val[bit_sel];
			ICT_OP_SKIP_BIT_SET: skip_take = rd_val[bit_sel];
			default: skip_take = 1'b0;
		endcase
	end

	ict_alu u_alu (
		.op(op),
		.a(acc_reg),
		.b(b_opnd),
		.c_in(c_reg),
		.bit_sel(bit_sel),
		.res(alu_res),
		.c_out(alu_c),
		.c_we(alu_cwe),
		.z_we(alu_zwe)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		phase_next = phase_reg + 2'h1;
		strobe_next = (phase_next == `ICT_LAST_PHASE);
		pc_next = pc_reg;
		pmem_addr_next = pmem_addr_reg;
		acc_next = acc_reg;
		c_next = c_reg;
		z_next = z_reg;
		sp_next = sp_reg;
		flush_next = flush_reg;
		tbl_pend_next = tbl_pend_reg;
		tbl_dst_next = tbl_dst_reg;
		tbl_high_next = tbl_high_reg;
		port_out_next = port_out_reg;
		halted_next = halted_reg;
		wdt_clear_next = 1'b0;
		mem_we = 1'b0;
		mem_wa = arg;
		mem_wd = alu_res;
		stk_we = 1'b0;
		to_pc_low = 1'b0;
		if (phase_reg == `ICT_LAST_PHASE) begin
			if (halted_reg) begin
				halted_next = !wake_sync_reg;
			end else if (tbl_pend_reg) begin
				// Second cycle of a table read: the word fetched is data
				mem_we = 1'b1;
				mem_wa = tbl_dst_reg;
				mem_wd = pmem_data[7:0];
				tbl_high_next = pmem_data[15:8];
				tbl_pend_next = 1'b0;
				pmem_addr_next = pc_reg;
			end else if (flush_reg) begin
				// Dummy cycle: the word fetched is discarded
				flush_next = 1'b0;
			end else begin
				pc_next = pc_inc;
				if (alu_cwe) begin
					c_next = alu_c;
				end
				if (alu_zwe) begin
					z_next = (alu_res == 8'h00);
				end
				if (is_dual || op inside {ICT_OP_MOVE_A_M, ICT_OP_MOVE_A_X}
					|| is_imm) begin
					if (is_dual && dest_m) begin
						mem_we = 1'b1;
					end else begin
						acc_next = alu_res;
					end
				end
				if (op inside {ICT_OP_MOVE_M_A, ICT_OP_BIT_FORCE_HIGH,
					ICT_OP_BIT_FORCE_LOW}) begin
					mem_we = 1'b1;
				end
				unique case (op)
					ICT_OP_UNCONDITIONAL_BRANCH: begin
						pc_next = target;
						flush_next = 1'b1;
					end
					ICT_OP_CALL: begin
						stk_we = 1'b1;
						sp_next = sp_reg + 3'h1;
						pc_next = target;
						flush_next = 1'b1;
					end
					ICT_OP_SUBROUTINE_RETURN, ICT_OP_INTERRUPT_RETURN: begin
						sp_next = stk_idx;
						pc_next = stk_top;
						flush_next = 1'b1;
					end
					ICT_OP_TABLE_READ: begin
						tbl_pend_next = 1'b1;
						tbl_dst_next = arg;
						pmem_addr_next = tbl_addr;
					end
					ICT_OP_HALT: halted_next = 1'b1;
					ICT_OP_WATCHDOG_CLEAR: wdt_clear_next = 1'b1;
					default: begin
						if (is_skip && skip_take) begin
							pc_next = pc_reg + 12'h002;
							flush_next = 1'b1;
						end
					end
				endcase
				if (mem_we && mem_wa == `ICT_ADDR_PC_LOW) begin
					to_pc_low = 1'b1;
					pc_next = {pc_inc[11:8], mem_wd};
					flush_next = 1'b1;
				end
				if (!tbl_pend_next) begin
					pmem_addr_next = pc_next;
				end
			end
		end
		if (mem_we && mem_wa == `ICT_ADDR_PORT_OUT) begin
			port_out_next = mem_wd;
		end
		if (mem_we && mem_wa == `ICT_ADDR_TBL_HIGH) begin
			tbl_high_next = mem_wd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (!resetn) begin
			phase_reg <= 2'h0;
			pc_reg <= `ICT_RST_PC;
			pmem_addr_reg <= `ICT_RST_PC;
			acc_reg <= `ICT_RST_BYTE;
			c_reg <= 1'b0;
			z_reg <= 1'b0;
			sp_reg <= 3'h0;
			flush_reg <= 1'b0;
			tbl_pend_reg <= 1'b0;
			tbl_dst_reg <= `ICT_RST_BYTE;
			tbl_high_reg <= `ICT_RST_BYTE;
			port_out_reg <= `ICT_RST_BYTE;
			halted_reg <= 1'b0;
			wdt_clear_reg <= 1'b0;
			strobe_reg <= 1'b0;
			port_meta_reg <= `ICT_RST_BYTE;
			port_sync_reg <= `ICT_RST_BYTE;
			wake_meta_reg <= 1'b0;
			wake_sync_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			pc_reg <= pc_next;
			pmem_addr_reg <= pmem_addr_next;
			acc_reg <= acc_next;
			c_reg <= c_next;
			z_reg <= z_next;
			sp_reg <= sp_next;
			flush_reg <= flush_next;
			tbl_pend_reg <= tbl_pend_next;
			tbl_dst_reg <= tbl_dst_next;
			tbl_high_reg <= tbl_high_next;
			port_out_reg <= port_out_next;
			halted_reg <= halted_next;
			wdt_clear_reg <= wdt_clear_next;
			strobe_reg <= strobe_next;
			port_meta_reg <= port_in;
			port_sync_reg <= port_meta_reg;
			wake_meta_reg <= wake_pin;
			wake_sync_reg <= wake_meta_reg;
		end
	end

	// Data and stack storage carry no reset; software initialises them
	always_ff @(posedge clk) begin
		if (mem_we) begin
			dmem[mem_wa] <= mem_wd;
		end
		if (stk_we) begin
			stack[sp_reg] <= pc_inc;
		end
	end

	assign pmem_addr = pmem_addr_reg;
	assign port_out = port_out_reg;
	assign acc = acc_reg;
	assign carry_flag = c_reg;
	assign zero_flag = z_reg;
	assign cycle_strobe = strobe_reg;
	assign powered_down = halted_reg;
	assign wdt_clear = wdt_clear_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_cycle_four;
		@(posedge clk) disable iff (!resetn)
		$rose(cycle_strobe) |=> !cycle_strobe [*3] ##1 cycle_strobe;
	endproperty
	a_cycle_four: assert property (p_cycle_four) else $error("cycle not four clocks");

	property p_two_cycle;
		@(posedge clk) disable iff (!resetn)
		exec && op inside {ICT_OP_UNCONDITIONAL_BRANCH, ICT_OP_CALL,
			ICT_OP_SUBROUTINE_RETURN, ICT_OP_INTERRUPT_RETURN}
		|=> flush_reg [*4] ##1 !flush_reg;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("branch not two cycles");

	property p_pc_low_jump;
		@(posedge clk) disable iff (!resetn)
		exec && to_pc_low |=> flush_reg && pc_reg[7:0] == $past(mem_wd);
	endproperty
	a_pc_low_jump: assert property (p_pc_low_jump) else $error("low byte write no jump");

	property p_skip_none;
		@(posedge clk) disable iff (!resetn)
		exec && is_skip && !skip_take |=> !flush_reg && pc_reg == $past(pc_inc);
	endproperty
	a_skip_none: assert property (p_skip_none) else $error("untaken skip slowed");

	property p_skip_taken;
		@(posedge clk) disable iff (!resetn)
		exec && is_skip && skip_take && !to_pc_low
		|=> flush_reg && pc_reg == $past(pc_reg) + 12'h002;
	endproperty
	a_skip_taken: assert property (p_skip_taken) else $error("taken skip wrong");

	property p_add_carry;
		@(posedge clk) disable iff (!resetn)
		exec && op == ICT_OP_ADD |=> c_reg == (({1'b0, $past(acc_reg)}
			+ {1'b0, $past(b_opnd)}) > 9'h0FF);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

	property p_sub_borrow;
		@(posedge clk) disable iff (!resetn)
		exec && op == ICT_OP_SUB |=> c_reg == ($past(acc_reg) >= $past(b_opnd));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow wrong");

	property p_inc_one;
		@(posedge clk) disable iff (!resetn)
		exec && op == ICT_OP_INCREMENT && !dest_m |=> acc_reg == $past(rd_val) + 8'h01;
	endproperty
	a_inc_one: assert property (p_inc_one) else $error("increment not one");

	property p_logic_zero;
		@(posedge clk) disable iff (!resetn)
		exec && op inside {ICT_OP_AND, ICT_OP_OR, ICT_OP_XOR, ICT_OP_BITWISE_COMPLEMENT}
		|=> z_reg == ($past(alu_res) == 8'h00);
	endproperty
	a_logic_zero: assert property (p_logic_zero) else $error("zero flag wrong");

	property p_rotate_carry;
		@(posedge clk) disable iff (!resetn)
		exec && op == ICT_OP_ROTATE_LEFT_VIA_FLAG |=> c_reg == $past(rd_val[7]);
	endproperty
	a_rotate_carry: assert property (p_rotate_carry) else $error("rotate carry wrong");

	property p_call_return;
		@(posedge clk) disable iff (!resetn)
		exec && op == ICT_OP_SUBROUTINE_RETURN |=> pc_reg == $past(stk_top);
	endproperty
	a_call_return: assert property (p_call_return) else $error("return address wrong");

	property p_bit_only;
		@(posedge clk) disable iff (!resetn)
		exec && op == ICT_OP_BIT_FORCE_LOW |-> mem_we && (mem_wd | (8'h01 << bit_sel))
			== (rd_val | (8'h01 << bit_sel)) && !mem_wd[bit_sel];
	endproperty
	a_bit_only: assert property (p_bit_only) else $error("bit force touched others");

	property p_halt;
		@(posedge clk) disable iff (!resetn)
		exec && op == ICT_OP_HALT |=> powered_down;
	endproperty
	a_halt: assert property (p_halt) else $error("halt ignored");

	c_call: cover property (@(posedge clk) disable iff (!resetn) exec && op == ICT_OP_CALL);
	c_skip: cover property (@(posedge clk) disable iff (!resetn) exec && is_skip && skip_take);
	c_table: cover property (@(posedge clk) disable iff (!resetn)
		exec && op == ICT_OP_TABLE_READ);
	c_wake: cover property (@(posedge clk) disable iff (!resetn) $fell(powered_down));

endmodule

// ===== verif/ict_core_tb.sv
// Self-checking bench of the instruction cycle timing core.
// Assumes core/ is on the include path; the bench plays program memory.
`include "ict_consts.svh"

module ict_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ict_pkg::*;

	typedef struct {
		logic [17:0] word;
		logic [7:0] acc;
		logic c;
		logic z;
		logic [7:0] port;
	} ict_step_s;

	logic clk;
	logic resetn;
	ict_addr_t pmem_addr;
	logic [`ICT_IW-1:0] pmem_data;
	logic [7:0] port_in;
	logic [7:0] port_out;
	logic wake_pin;
	logic [7:0] acc;
	logic carry_flag;
	logic zero_flag;
	logic cycle_strobe;
	logic powered_down;
	logic wdt_clear;
	logic [17:0] rom [0:4095];
	ict_step_s steps[$];
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int base_count = 0;

	ict_core dut (
		.clk(clk),
		.resetn(resetn),
		.pmem_addr(pmem_addr),
		.pmem_data(pmem_data),
		.port_in(port_in),
		.port_out(port_out),
		.wake_pin(wake_pin),
		.acc(acc),
		.carry_flag(carry_flag),
		.zero_flag(zero_flag),
		.cycle_strobe(cycle_strobe),
		.powered_down(powered_down),
		.wdt_clear(wdt_clear)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Program memory answers one clock after the address, well before phase 3
	always @(posedge clk) begin
		pmem_data <= rom[pmem_addr];
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			$display("ERROR at %0t ns: run did not finish", $time);
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] expected, input string what);
		samples_checked++;
		if (seen !== expected) begin
			mismatches++;
			$display("ERROR at %0t ns: %s seen %h expected %h", $time, what, seen, expected);
		end
	endtask

	function automatic logic [17:0] w(ict_op_e op, logic d, logic [2:0] b, logic [7:0] a);
		return {op, d, b, a};
	endfunction

	function automatic logic [17:0] jw(ict_op_e op, logic [11:0] t);
		return {op, t};
	endfunction

	task automatic add(logic [17:0] word, logic [7:0] a, logic c, logic z, logic [7:0] p);
		steps.push_back('{word, a, c, z, p});
	endtask

	task automatic clear_rom;
		foreach (rom[i]) rom[i] = 18'h00000;
		steps.delete();
	endtask

	task automatic do_reset;
		@(posedge clk);
		resetn <= 1'b0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
	endtask

	// Counts edges from release until power-down shows; a fixed offset cancels out
	task automatic run_to_halt(output int n);
		do_reset();
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (powered_down !== 1'b1 && n < 400);
	endtask

	task automatic wait_strobe(output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (cycle_strobe !== 1'b1 && k < 10);
	endtask

	// Single-cycle programs only: every strobe is then an executing cycle
	task automatic run_steps;
		int k;
		foreach (steps[i]) rom[i] = steps[i].word;
		rom[steps.size()] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		do_reset();
		foreach (steps[i]) begin
			wait_strobe(k);
			if (i > 0) check(k, 3, "strobe spacing");
			@(posedge clk);
			#1;
			check(acc, steps[i].acc, "acc");
			check(carry_flag, steps[i].c, "carry");
			check(zero_flag, steps[i].z, "zero");
			check(port_out, steps[i].port, "port");
		end
		repeat (5) @(posedge clk);
		#1;
		check(powered_down, 1'b1, "halted");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_baseline;
		clear_rom();
		rom[0] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		run_to_halt(base_count);
		check(base_count >= 4 && base_count <= 5, 1'b1, "first halt");
		$display("Test baseline done");
	endtask

	task automatic test_call_jump;
		int n;
		clear_rom();
		rom[0] = jw(ICT_OP_CALL, 12'h010);
		rom[1] = w(ICT_OP_ADD_X, 1'b0, 3'h0, 8'h01);
		rom[2] = jw(ICT_OP_UNCONDITIONAL_BRANCH, 12'h020);
		rom[16] = w(ICT_OP_MOVE_A_X, 1'b0, 3'h0, 8'h5A);
		rom[17] = w(ICT_OP_SUBROUTINE_RETURN, 1'b0, 3'h0, 8'h00);
		rom[32] = jw(ICT_OP_CALL, 12'h030);
		rom[33] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		rom[48] = w(ICT_OP_INTERRUPT_RETURN, 1'b0, 3'h0, 8'h00);
		run_to_halt(n);
		check(n, base_count + 48, "call and jump timing");
		check(acc, 8'h5B, "acc after return");
		$display("Test call and jump done");
	endtask

	task automatic test_alu;
		clear_rom();
		add(w(ICT_OP_MOVE_A_X, 1'b0, 3'h0, 8'hF0), 8'hF0, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_MOVE_M_A, 1'b1, 3'h0, 8'h40), 8'hF0, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_ADD_X, 1'b0, 3'h0, 8'h20), 8'h10, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_ADD_X, 1'b0, 3'h0, 8'hF0), 8'h00, 1'b1, 1'b1, 8'h00);
		add(w(ICT_OP_SUB_X, 1'b0, 3'h0, 8'h01), 8'hFF, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_SUB_X, 1'b0, 3'h0, 8'hFF), 8'h00, 1'b1, 1'b1, 8'h00);
		add(w(ICT_OP_ADD, 1'b0, 3'h0, 8'h40), 8'hF0, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_SUB, 1'b0, 3'h0, 8'h40), 8'h00, 1'b1, 1'b1, 8'h00);
		add(w(ICT_OP_ADD_CARRY, 1'b0, 3'h0, 8'h40), 8'hF1, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_SUB_CARRY_X, 1'b0, 3'h0, 8'hF1), 8'hFF, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_SUB_CARRY, 1'b0, 3'h0, 8'h40), 8'h0E, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_XOR_X, 1'b0, 3'h0, 8'h0E), 8'h00, 1'b1, 1'b1, 8'h00);
		add(w(ICT_OP_OR_X, 1'b0, 3'h0, 8'h0F), 8'h0F, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_AND_X, 1'b0, 3'h0, 8'h3C), 8'h0C, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_AND, 1'b0, 3'h0, 8'h40), 8'h00, 1'b1, 1'b1, 8'h00);
		add(w(ICT_OP_OR, 1'b0, 3'h0, 8'h40), 8'hF0, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_XOR, 1'b0, 3'h0, 8'h40), 8'h00, 1'b1, 1'b1, 8'h00);
		add(w(ICT_OP_BITWISE_COMPLEMENT, 1'b0, 3'h0, 8'h40), 8'h0F, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_INCREMENT, 1'b0, 3'h0, 8'h40), 8'hF1, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_SUBTRACT_ONE_FROM_MEMORY, 1'b1, 3'h0, 8'h40), 8'hF1, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_MOVE_A_M, 1'b0, 3'h0, 8'h40), 8'hEF, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_ADD_X, 1'b0, 3'h0, 8'h00), 8'hEF, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_ROTATE_RIGHT_VIA_FLAG, 1'b0, 3'h0, 8'h40), 8'h77, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_ROTATE_LEFT_VIA_FLAG, 1'b0, 3'h0, 8'h40), 8'hDF, 1'b1, 1'b0, 8'h00);
		add(w(ICT_OP_ADD_X, 1'b0, 3'h0, 8'h00), 8'hDF, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_ROTATE_RIGHT, 1'b0, 3'h0, 8'h40), 8'hF7, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_ROTATE_LEFT, 1'b0, 3'h0, 8'h40), 8'hDF, 1'b0, 1'b0, 8'h00);
		run_steps();
		$display("Test arithmetic and logic done");
	endtask

	task automatic test_port_bits;
		clear_rom();
		add(w(ICT_OP_MOVE_A_X, 1'b0, 3'h0, 8'hA5), 8'hA5, 1'b0, 1'b0, 8'h00);
		add(w(ICT_OP_MOVE_M_A, 1'b1, 3'h0, 8'h14), 8'hA5, 1'b0, 1'b0, 8'hA5);
		add(w(ICT_OP_BIT_FORCE_LOW, 1'b1, 3'h0, 8'h14), 8'hA5, 1'b0, 1'b0, 8'hA4);
		add(w(ICT_OP_BIT_FORCE_HIGH, 1'b1, 3'h6, 8'h14), 8'hA5, 1'b0, 1'b0, 8'hE4);
		add(w(ICT_OP_BIT_FORCE_LOW, 1'b1, 3'h7, 8'h14), 8'hA5, 1'b0, 1'b0, 8'h64);
		add(w(ICT_OP_MOVE_A_M, 1'b0, 3'h0, 8'h15), 8'h3C, 1'b0, 1'b0, 8'h64);
		add(w(ICT_OP_MOVE_A_M, 1'b0, 3'h0, 8'h14), 8'h64, 1'b0, 1'b0, 8'h64);
		add(w(ICT_OP_MOVE_M_A, 1'b1, 3'h0, 8'h43), 8'h64, 1'b0, 1'b0, 8'h64);
		add(w(ICT_OP_BIT_FORCE_HIGH, 1'b1, 3'h0, 8'h43), 8'h64, 1'b0, 1'b0, 8'h64);
		add(w(ICT_OP_MOVE_A_M, 1'b0, 3'h0, 8'h43), 8'h65, 1'b0, 1'b0, 8'h64);
		run_steps();
		$display("Test port and bit forcing done");
	endtask

	task automatic test_skips;
		int n;
		clear_rom();
		rom[0] = w(ICT_OP_MOVE_A_X, 1'b0, 3'h0, 8'h00);
		rom[1] = w(ICT_OP_MOVE_M_A, 1'b1, 3'h0, 8'h41);
		rom[2] = w(ICT_OP_SKIP_ZERO, 1'b0, 3'h0, 8'h41);
		rom[3] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		rom[4] = w(ICT_OP_SKIP_NOT_ZERO, 1'b0, 3'h0, 8'h41);
		rom[5] = w(ICT_OP_MOVE_A_X, 1'b0, 3'h0, 8'h08);
		rom[6] = w(ICT_OP_MOVE_M_A, 1'b1, 3'h0, 8'h41);
		rom[7] = w(ICT_OP_SKIP_BIT_SET, 1'b0, 3'h3, 8'h41);
		rom[8] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		rom[9] = w(ICT_OP_SKIP_BIT_ZERO, 1'b0, 3'h3, 8'h41);
		rom[10] = w(ICT_OP_MOVE_A_X, 1'b0, 3'h0, 8'h20);
		rom[11] = w(ICT_OP_MOVE_M_A, 1'b1, 3'h0, 8'h02);
		rom[12] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		rom[32] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		run_to_halt(n);
		check(n, base_count + 52, "skip and low byte timing");
		check(acc, 8'h20, "acc after skips");
		$display("Test skips done");
	endtask

	task automatic test_table;
		int n;
		clear_rom();
		rom[0] = w(ICT_OP_MOVE_A_X, 1'b0, 3'h0, 8'h30);
		rom[1] = w(ICT_OP_MOVE_M_A, 1'b1, 3'h0, 8'h07);
		rom[2] = w(ICT_OP_TABLE_READ, 1'b1, 3'h0, 8'h42);
		rom[3] = w(ICT_OP_MOVE_A_M, 1'b0, 3'h0, 8'h42);
		rom[4] = w(ICT_OP_ADD, 1'b0, 3'h0, 8'h08);
		rom[5] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		rom[48] = 18'h2A53C;
		run_to_halt(n);
		check(n, base_count + 24, "table read timing");
		check(acc, 8'hE1, "table bytes sum");
		check(carry_flag, 1'b0, "table sum carry");
		$display("Test table read done");
	endtask

	task automatic test_halt_wake;
		int k;
		int hits;
		clear_rom();
		rom[0] = w(ICT_OP_WATCHDOG_CLEAR, 1'b0, 3'h0, 8'h00);
		rom[1] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		rom[2] = w(ICT_OP_MOVE_A_X, 1'b0, 3'h0, 8'h77);
		rom[3] = w(ICT_OP_HALT, 1'b0, 3'h0, 8'h00);
		do_reset();
		wait_strobe(k);
		hits = 0;
		repeat (3) begin
			@(posedge clk);
			#1;
			hits += (wdt_clear === 1'b1);
		end
		check(hits, 1, "watchdog pulse");
		repeat (20) @(posedge clk);
		#1;
		check(powered_down, 1'b1, "stays halted");
		check(acc, 8'h00, "nothing runs halted");
		@(posedge clk);
		wake_pin <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (powered_down === 1'b1 && k < 20);
		@(posedge clk);
		wake_pin <= 1'b0;
		repeat (12) @(posedge clk);
		#1;
		check(acc, 8'h77, "resumed after wake");
		check(powered_down, 1'b1, "halted again");
		$display("Test halt and wake done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		pmem_data = 18'h00000;
		port_in = 8'h3C;
		wake_pin = 1'b0;
		clear_rom();
		test_baseline();
		test_call_jump();
		test_alu();
		test_port_bits();
		test_skips();
		test_table();
		test_halt_wake();
		tally_and_finish();
	end
endmodule
